// ==== rtl/edge_interrupt_request_logic.sv ====
`timescale 1ns/10ps
`include "edge_irq_regs.svh"
// Notes on behaviour
// - pins are general I/O by default; alternate select routes them to interrupts
// - two independent requests, each from its own pair of pins
// - three priority levels 1 to 3, 3 highest
// - each source has a software priority level
// - at equal priority interrupt one wins, then zero, then others
// - per pin edge detector: rising, falling or both
// - detected edge sets a request flop that drives the request output
// - request flop clears automatically when its interrupt is taken
// - lower priority take within 8 clocks of setting edge wrongly clears flop
// - higher priority request within 8 clocks leaves taken flop set
// - tied inputs raise both requests; at equal priority interrupt one serviced first
// - one external interrupt never causes a spurious request on the other
module edge_interrupt_request_logic
  import edge_irq_pkg::*;
#(
  parameter int HAZARD = `HAZARD_CLOCKS
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // port pins
  input  wire logic       port_e_pin_zero,
  input  wire logic       port_e_pin_one,
  input  wire logic       port_e_pin_four,
  input  wire logic       port_e_pin_five,
  // configuration
  input  wire logic [3:0] alt_func_en,
  input  wire logic [7:0] pin_edge_sel,
  input  wire logic [1:0] irq_zero_prio,
  input  wire logic [1:0] irq_one_prio,
  // other on-chip sources
  input  wire logic [1:0] other_req_prio,
  input  wire logic       other_taken,
  // processor acknowledge
  input  wire logic [1:0] cpu_level,
  input  wire logic       take_ack,
  // general purpose view of pins
  output logic [3:0]      gpio_in,
  // requests and grant
  output logic            irq_zero_req,
  output logic            irq_one_req,
  output logic [1:0]      take_irq,
  output logic [1:0]      take_prio
);
  logic [3:0] pins_w;
  logic [3:0] hit_w;
  logic       req_r [2];
  logic       hi_r [2];
  logic [`HAZARD_CNT_W-1:0] win_r [2];
  grant_e     grant_w;
  logic [3:0] gpio_r;
  logic [1:0] take_r;
  prio_t      tprio_r;

  assign pins_w = {port_e_pin_five, port_e_pin_four, port_e_pin_one, port_e_pin_zero};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      edge_pin_if pif ();
      assign pif.pin      = pins_w[g] & alt_func_en[g];
      assign pif.edge_sel = pin_edge_sel[2*g+1:2*g];
      assign hit_w[g]     = pif.hit;
      pin_edge_detect u_det (
        .clk   (clk),
        .reset (reset),
        .p     (pif)
      );
    end
  endgenerate

  // pins 0,2 feed interrupt zero; pins 1,3 feed interrupt one
  wire set0_w = hit_w[0] | hit_w[2];
  wire set1_w = hit_w[1] | hit_w[3];

  function automatic logic beats(input prio_t a, input prio_t b);
    beats = (a != `PRIO_NONE) && (a >= b);
  endfunction

  // arbitration among pending external requests
  wire ok1_w = req_r[1] && beats(irq_one_prio, irq_zero_prio & {2{req_r[0]}}) &&
               beats(irq_one_prio, other_req_prio) && (irq_one_prio > cpu_level);
  wire ok0_w = req_r[0] && !ok1_w && (irq_zero_prio != `PRIO_NONE) &&
               beats(irq_zero_prio, other_req_prio) && (irq_zero_prio > cpu_level);
  always_comb begin
    grant_w = GRANT_NONE;
    if (ok1_w) begin
      grant_w = GRANT_ONE;
    end else if (ok0_w) begin
      grant_w = GRANT_ZERO;
    end
  end

  wire [1:0] ext_prio_w [2];
  assign ext_prio_w[0] = irq_zero_prio;
  assign ext_prio_w[1] = irq_one_prio;
  wire [1:0] taken_w = {take_ack & (grant_w == GRANT_ONE), take_ack & (grant_w == GRANT_ZERO)};

  generate
    for (g = 0; g < 2; g++) begin : g_req
      wire set_w  = g ? set1_w : set0_w;
      wire open_w = (win_r[g] != `CNT_ZERO) || set_w;
      // lower priority take near the setting edge clears wrongly
      wire lose_w = other_taken && (other_req_prio < ext_prio_w[g]) && open_w;
      // higher priority request near the edge keeps the flop set
      wire hi_w   = other_req_prio > ext_prio_w[g];
      wire keep_w = (hi_w || hi_r[g]) && open_w;
      wire clr_w  = (taken_w[g] && !keep_w) || lose_w;
      always_ff @(posedge clk) begin
        if (reset) begin
          req_r[g] <= 1'b0;
          hi_r[g]  <= 1'b0;
          win_r[g] <= `CNT_ZERO;
        end else begin
          // remember a higher request seen at the setting edge
          if (set_w) begin
            hi_r[g] <= hi_w;
          end else if (win_r[g] == `CNT_ZERO) begin
            hi_r[g] <= 1'b0;
          end
          if (set_w) begin
            win_r[g] <= `HAZARD_CNT_W'(HAZARD);
          end else if (win_r[g] != `CNT_ZERO) begin
            win_r[g] <= win_r[g] - 1'b1;
          end
          // own set and own clear only; other request never touches it
          if (clr_w && !(set_w && !lose_w)) begin
            req_r[g] <= 1'b0;
          end else if (set_w) begin
            req_r[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      gpio_r       <= 4'h0;
      irq_zero_req <= 1'b0;
      irq_one_req  <= 1'b0;
      take_r       <= 2'h0;
      tprio_r      <= `PRIO_NONE;
    end else begin
      gpio_r       <= pins_w;
      irq_zero_req <= req_r[0];
      irq_one_req  <= req_r[1];
      take_r       <= taken_w;
      tprio_r      <= taken_w[1] ? irq_one_prio :
                      taken_w[0] ? irq_zero_prio : `PRIO_NONE;
    end
  end

  assign gpio_in   = gpio_r;
  assign take_irq  = take_r;
  assign take_prio = tprio_r;
endmodule

// ==== rtl/edge_irq_pkg.sv ====
package edge_irq_pkg;
  typedef logic [1:0] edge_sel_t;
  typedef logic [1:0] prio_t;
  typedef enum logic [2:0] {
    GRANT_NONE  = 3'b001,
    GRANT_ZERO  = 3'b010,
    GRANT_ONE   = 3'b100
  } grant_e;
endpackage

// ==== rtl/edge_irq_regs.svh ====
`ifndef EDGE_IRQ_REGS_SVH
`define EDGE_IRQ_REGS_SVH
// edge select codes
`define EDGE_SEL_OFF     2'h0
`define EDGE_SEL_FALL    2'h1
`define EDGE_SEL_RISE    2'h2
`define EDGE_SEL_BOTH    2'h3
// priority levels
`define PRIO_NONE        2'h0
`define PRIO_HIGHEST     2'h3
// clear hazard window
`define HAZARD_CLOCKS    8
`define HAZARD_CNT_W     4
`define CNT_ZERO         4'h0
`endif

// ==== rtl/edge_pin_if.sv ====
`timescale 1ns/10ps
interface edge_pin_if;
  logic [1:0] edge_sel;
  logic       pin;
  logic       hit;
  modport det (input edge_sel, input pin, output hit);
  modport ctl (output edge_sel, output pin, input hit);
endinterface

// ==== rtl/pin_edge_detect.sv ====
`timescale 1ns/10ps
`include "edge_irq_regs.svh"
module pin_edge_detect
  import edge_irq_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // pin and result
  edge_pin_if.det   p
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  wire  rise_w = sync2_r & ~prev_r;
  wire  fall_w = ~sync2_r & prev_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= p.pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end
  assign p.hit = (p.edge_sel[1] & rise_w) | (p.edge_sel[0] & fall_w);
endmodule

// ==== testbench/edge_irq_assertions.sv ====
`timescale 1ns/10ps
module edge_irq_assertions (
  // clock, reset, pins and controls
  input wire logic       clk, reset, take_ack,
  input wire logic       port_e_pin_zero, port_e_pin_one, port_e_pin_four, port_e_pin_five,
  input wire logic [1:0] cpu_level, irq_zero_prio, irq_one_prio,
  // results
  input wire logic       irq_zero_req, irq_one_req,
  input wire logic [1:0] take_irq, take_prio,
  input wire logic [3:0] gpio_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence took;
    take_irq != 2'h0;
  endsequence
  reset_clears_a: assert property (disable iff (1'b0) reset |=>
    !irq_zero_req && !irq_one_req && take_irq == 2'h0) else $error("reset left outputs set");
  take_cause_a: assert property (took |-> $past(take_ack))
    else $error("take without acknowledge");
  above_cpu_a: assert property (took |-> take_prio > $past(cpu_level))
    else $error("take at or below cpu level");
  prio_one_a: assert property (take_irq[1] |-> take_prio == $past(irq_one_prio))
    else $error("wrong level for interrupt one");
  prio_zero_a: assert property (take_irq[0] |-> take_prio == $past(irq_zero_prio))
    else $error("wrong level for interrupt zero");
  idle_prio_a: assert property (take_irq == 2'h0 |-> take_prio == 2'h0)
    else $error("level shown without take");
  single_take_a: assert property (take_irq != 2'h3) else $error("two takes at once");
  gpio_copy_a: assert property (!$past(reset) |-> gpio_in ==
    $past({port_e_pin_five, port_e_pin_four, port_e_pin_one, port_e_pin_zero}))
    else $error("pin copy wrong");
endmodule
bind edge_interrupt_request_logic edge_irq_assertions u_chk (.clk, .reset, .take_ack,
  .port_e_pin_zero, .port_e_pin_one, .port_e_pin_four, .port_e_pin_five, .cpu_level,
  .irq_zero_prio, .irq_one_prio, .irq_zero_req, .irq_one_req, .take_irq, .take_prio, .gpio_in);

// ==== testbench/pin_source.sv ====
`timescale 1ns/10ps
module pin_source (
  // levels asked for and tie strap
  input wire logic [3:0] lvl,
  input wire logic       tie,
  // pins in order zero, one, four, five
  output logic [3:0]     pin
);
  assign pin = tie ? {lvl[3:2], lvl[0], lvl[0]} : lvl;
endmodule

// ==== testbench/test_edge_interrupt_request_logic.sv ====
`timescale 1ns/10ps
module test_edge_interrupt_request_logic;
  logic       clk = 0, reset = 1, tie = 0, take_ack = 0, other_taken = 0;
  logic       irq_zero_req, irq_one_req;
  logic [1:0] other_req_prio = 2'h0;
  logic [3:0] lvl = 4'h0, alt_func_en = 4'hf, pin, gpio_in;
  logic [7:0] pin_edge_sel = 8'h6a;
  logic [1:0] irq_zero_prio = 2'h1, irq_one_prio = 2'h1, cpu_level = 2'h0, take_irq, take_prio;
  int         errors = 0, checks_done = 0;
  initial forever #25 clk = ~clk;
  pin_source u_src (.lvl(lvl), .tie(tie), .pin(pin));
  edge_interrupt_request_logic #(.HAZARD(2)) u_dut (.clk(clk), .reset(reset),
    .port_e_pin_zero(pin[0]), .port_e_pin_one(pin[1]), .port_e_pin_four(pin[2]),
    .port_e_pin_five(pin[3]), .alt_func_en(alt_func_en), .pin_edge_sel(pin_edge_sel),
    .irq_zero_prio(irq_zero_prio), .irq_one_prio(irq_one_prio),
    .other_req_prio(other_req_prio), .other_taken(other_taken),
    .cpu_level(cpu_level), .take_ack(take_ack), .gpio_in(gpio_in),
    .irq_zero_req(irq_zero_req), .irq_one_req(irq_one_req), .take_irq(take_irq),
    .take_prio(take_prio));
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task pins(input logic [3:0] v);
    lvl = v;
    repeat (8) @(negedge clk);
  endtask
  task take(input logic [1:0] ti, input logic [1:0] tp);
    take_ack = 1'b1;
    @(negedge clk);
    take_ack = 1'b0;
    chk(take_irq, ti);
    chk(take_prio, tp);
    repeat (3) @(negedge clk);
  endtask
  task spur(input logic [1:0] zp, input logic [3:0] left);
    pins(4'h0);
    irq_zero_prio = zp;
    lvl = 4'h1;
    repeat (2) @(negedge clk);
    other_req_prio = 2'h2;
    @(negedge clk);
    other_req_prio = 2'h0;
    take(2'h1, zp);
    chk({irq_one_req, irq_zero_req}, left);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #50000;
    errors++;
    complete_run;
  end
  initial begin
    repeat (12) @(negedge clk);
    reset = 0;
    repeat (4) @(negedge clk);
    pins(4'h1);
    chk({irq_one_req, irq_zero_req}, 4'h1);
    chk(gpio_in, 4'h1);
    take(2'h1, 2'h1);
    chk({irq_one_req, irq_zero_req}, 4'h0);
    $display("single edge test done");
    pins(4'h9);
    chk({irq_one_req, irq_zero_req}, 4'h0);
    pins(4'h1);
    chk({irq_one_req, irq_zero_req}, 4'h2);
    take(2'h2, 2'h1);
    $display("falling edge test done");
    alt_func_en = 4'hb;
    pins(4'h5);
    chk({irq_one_req, irq_zero_req}, 4'h0);
    pins(4'h1);
    alt_func_en = 4'hf;
    pins(4'h0);
    $display("disabled pin test done");
    tie = 1'b1;
    irq_zero_prio = 2'h2;
    irq_one_prio = 2'h2;
    pins(4'h1);
    chk({irq_one_req, irq_zero_req}, 4'h3);
    cpu_level = 2'h2;
    take(2'h0, 2'h0);
    cpu_level = 2'h0;
    take(2'h2, 2'h2);
    chk({irq_one_req, irq_zero_req}, 4'h1);
    take(2'h1, 2'h2);
    chk({irq_one_req, irq_zero_req}, 4'h0);
    $display("tied input test done");
    tie = 1'b0;
    pins(4'h0);
    other_req_prio = 2'h1;
    lvl = 4'h1;
    repeat (2) @(negedge clk);
    other_taken = 1'b1;
    @(negedge clk);
    other_taken = 1'b0;
    repeat (5) @(negedge clk);
    chk({irq_one_req, irq_zero_req}, 4'h0);
    $display("lost request test done");
    spur(2'h1, 4'h1);
    take(2'h1, 2'h1);
    chk({irq_one_req, irq_zero_req}, 4'h0);
    spur(2'h2, 4'h0);
    $display("spurious request test done");
    complete_run;
  end
endmodule
